// >>> design/status_defines.vh
// Purpose: shared constants of the standard event status block
// Assumes: 16-bit status registers, one clock domain
// Notes:   bit positions of the event latch and the status byte
`ifndef STATUS_DEFINES_VH
`define STATUS_DEFINES_VH

`define REG_WIDTH        16
`define REG_ZERO         16'h0000
`define EV_OP_DONE       0
`define EV_REQ_CTRL      1
`define EV_QUERY_ERR     2
`define EV_DEVICE_ERR    3
`define EV_EXEC_ERR      4
`define EV_CMD_ERR       5
`define EV_IMPL_MASK     16'h0039
`define SUMMARY_BIT_POS  5
`define STB_ZERO         8'h00

`endif

// >>> design/status_unit.v
// Purpose: generic 16-bit status register with enable mask and summary bit
// Assumes: conditions come from logic on the same clock
// Notes:   event bits latch rising conditions; read clears them
`timescale 1ns/1ns
`include "status_defines.vh"

module status_unit #(
  parameter WIDTH = `REG_WIDTH
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] condition,
  input  wire [WIDTH-1:0] enable_value,
  input  wire             enable_write,
  input  wire             event_read,
  output reg  [WIDTH-1:0] event_bits,
  output reg  [WIDTH-1:0] enable_mask,
  output wire             summary
);

  reg [WIDTH-1:0] cond_prev;

  // ----------------------------------------
  // latch and mask
  // ----------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cond_prev   <= {WIDTH{1'b0}};
      event_bits  <= {WIDTH{1'b0}};
      enable_mask <= {WIDTH{1'b0}};
    end else begin
      cond_prev <= condition;
      // set wins over the read clear
      event_bits <= (event_read ? {WIDTH{1'b0}} : event_bits) | (condition & ~cond_prev);
      if (enable_write) begin
        enable_mask <= enable_value;
      end
    end
  end

  assign summary = |(event_bits & enable_mask);

endmodule

// >>> design/std_event_status.v
// Purpose: standard event status latch, enable mask, summary and wait logic
// Assumes: one clock; event pulses come from the error/event queue logic
// Notes:   a second generic status register shows the 16-bit structure
`timescale 1ns/1ns
`include "status_defines.vh"

// Function
// - the summary bit is high whenever a latched event meets a set enable bit.
// - the enable mask is all zeros after power up.
// - reading the event latch returns its contents and clears it.
// - bit 0 sets only once the completion command is seen and nothing is pending.
// - bit 1 always reads zero.
// - bit 3 sets on a device-specific error.
// - bit 4 sets on an out-of-range or inconsistent data element.
// - bit 5 sets on a syntax error, unknown header or trigger inside a message.
// - bits 8 to 15 always read zero.
// - after a wait command no later command runs until nothing is pending.
// - every other status register is 16 bits with one summary bit.
// - the summary bit sits at bit 5 of the status byte.
// - event bits are set only by queue events and, for bit 0, the completion logic, never by direct writes.
module std_event_status #(
  parameter WIDTH = `REG_WIDTH
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire             queue_event_valid,
  input  wire             queue_device_err,
  input  wire             queue_exec_err,
  input  wire             queue_cmd_err,
  input  wire             op_done_cmd,
  input  wire             ops_pending,
  input  wire             wait_cmd,
  input  wire             enable_write,
  input  wire [WIDTH-1:0] enable_value,
  input  wire             latch_read,
  input  wire [WIDTH-1:0] aux_condition,
  input  wire [WIDTH-1:0] aux_enable_value,
  input  wire             aux_enable_write,
  input  wire             aux_read,
  output reg  [WIDTH-1:0] latch_value,
  output reg              latch_value_valid,
  output wire [WIDTH-1:0] enable_readback,
  output wire             event_summary,
  output wire [7:0]       status_byte_part,
  output wire             exec_hold,
  output reg  [WIDTH-1:0] aux_value,
  output wire             aux_summary
);

  localparam ST_RUN  = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg  [WIDTH-1:0] standard_event_latch;
  reg  [WIDTH-1:0] event_enable;
  reg              op_done_armed;
  reg              wait_state;
  reg              next_wait_state;
  reg  [WIDTH-1:0] set_bits;
  wire [WIDTH-1:0] aux_events;
  wire [WIDTH-1:0] aux_mask;

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  always @* begin
    set_bits = `REG_ZERO;
    set_bits[`EV_OP_DONE] = op_done_armed & ~ops_pending;
    if (queue_event_valid) begin
      set_bits[`EV_DEVICE_ERR] = queue_device_err;
      set_bits[`EV_EXEC_ERR]   = queue_exec_err;
      set_bits[`EV_CMD_ERR]    = queue_cmd_err;
    end
  end

  // ----------------------------------------
  // latch, enable mask, read answer
  // ----------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      standard_event_latch <= `REG_ZERO;
      event_enable         <= `REG_ZERO;
      op_done_armed        <= 1'b0;
      latch_value          <= `REG_ZERO;
      latch_value_valid    <= 1'b0;
    end else begin
      if (op_done_cmd) begin
        op_done_armed <= 1'b1;
      end else if (!ops_pending) begin
        op_done_armed <= 1'b0;
      end
      standard_event_latch <= ((latch_read ? `REG_ZERO : standard_event_latch) | set_bits)
                              & `EV_IMPL_MASK;
      latch_value_valid <= latch_read;
      if (latch_read) begin
        latch_value <= standard_event_latch;
      end
      if (enable_write) begin
        event_enable <= enable_value;
      end
    end
  end

  assign enable_readback = event_enable;

  assign event_summary = |(standard_event_latch & event_enable);

  assign status_byte_part = `STB_ZERO | ({7'h00, event_summary} << `SUMMARY_BIT_POS);

  // ----------------------------------------
  // wait-to-continue
  // ----------------------------------------
  always @* begin
    case (wait_state)
      ST_RUN:  next_wait_state = wait_cmd ? ST_WAIT : ST_RUN;
      ST_WAIT: next_wait_state = ops_pending ? ST_WAIT : ST_RUN;
      default: next_wait_state = ST_RUN;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_state <= ST_RUN;
    end else begin
      wait_state <= next_wait_state;
    end
  end

  assign exec_hold = (wait_state == ST_WAIT) & ops_pending;

  // ----------------------------------------
  // generic 16-bit status register
  // ----------------------------------------
  // standard register structure
  status_unit #(
    .WIDTH (WIDTH)
  ) u_aux (
    .clock        (clock),
    .arst_n       (arst_n),
    .condition    (aux_condition),
    .enable_value (aux_enable_value),
    .enable_write (aux_enable_write),
    .event_read   (aux_read),
    .event_bits   (aux_events),
    .enable_mask  (aux_mask),
    .summary      (aux_summary)
  );

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aux_value <= `REG_ZERO;
    end else if (aux_read) begin
      aux_value <= aux_events;
    end
  end

endmodule

// >>> dv/ses_props.sv
// Purpose: port assertions of the event status block
// Assumes: one clock, async active-low reset
// Notes:   bound to every block instance
`timescale 1ns/1ns
module ses_props #(
  parameter WIDTH = 16
) (
  input wire             clock,
  input wire             arst_n,
  input wire             queue_event_valid,
  input wire             queue_device_err,
  input wire             queue_exec_err,
  input wire             wait_cmd,
  input wire             ops_pending,
  input wire             enable_write,
  input wire             latch_read,
  input wire [WIDTH-1:0] enable_readback,
  input wire [WIDTH-1:0] latch_value,
  input wire             latch_value_valid,
  input wire             event_summary,
  input wire [7:0]       status_byte_part,
  input wire             exec_hold
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  byte_map_a:
    assert property (status_byte_part == {2'h0, event_summary, 5'h00}) else $error("byte");
  mask_rst_a:
    assert property (!$past(arst_n) |-> enable_readback == '0) else $error("mask rst");
  mask_gate_a:
    assert property (enable_readback == '0 |-> !event_summary) else $error("gate");
  exec_sum_a:
    assert property (queue_event_valid && queue_exec_err && enable_readback[4] && !enable_write
      |=> event_summary) else $error("exec");
  read_ans_a:
    assert property (latch_read |=> latch_value_valid) else $error("read");
  resv_zero_a:
    assert property (latch_value_valid |-> latch_value[15:8] == 8'h00 && !latch_value[1])
      else $error("resv");
  dev_keep_a:
    assert property (queue_event_valid && queue_device_err ##1 !latch_read ##1 latch_read
      |=> latch_value[3])
      else $error("dev");
  hold_a:
    assert property (wait_cmd && ops_pending ##1 ops_pending |-> exec_hold) else $error("hold");
  cover property (latch_value_valid && latch_value[4]);
  cover property (exec_hold);
  cover property (event_summary);
endmodule
bind std_event_status ses_props #(.WIDTH(WIDTH)) i_props (.*);

// >>> dv/controller_model.sv
// Purpose: remote controller issuing status commands
// Assumes: requests change at the falling edge
// Notes:   released error flags and enable value show the inverse value; strobes and commands return low
`timescale 1ns/1ns
module controller_model (
  input wire        clock,
  input wire [15:0] latch_value,
  input wire        latch_value_valid,
  output reg        queue_event_valid = 0, queue_device_err = 0, queue_exec_err = 0,
  output reg        queue_cmd_err = 0, op_done_cmd = 0, wait_cmd = 0, ops_pending = 0,
  output reg        enable_write = 0, latch_read = 0,
  output reg [15:0] enable_value = 16'h0000
);
  task send(input d, x, c); begin
    @(negedge clock) queue_event_valid = 1;
    {queue_device_err, queue_exec_err, queue_cmd_err} = {d, x, c};
    @(negedge clock) queue_event_valid = 0;
    {queue_device_err, queue_exec_err, queue_cmd_err} = ~{d, x, c};
  end endtask
  task cmd(input w); begin
    @(negedge clock) op_done_cmd = !w;
    wait_cmd = w;
    @(negedge clock) op_done_cmd = 0;
    wait_cmd = 0;
  end endtask
  task mask(input [15:0] v); begin
    @(negedge clock) enable_value = v;
    enable_write = 1;
    @(negedge clock) enable_write = 0;
    enable_value = ~v;
  end endtask
  task query(output [15:0] v, output ok); begin
    @(negedge clock) latch_read = 1;
    @(negedge clock) latch_read = 0;
    v = latch_value;
    ok = latch_value_valid;
  end endtask
endmodule

// >>> dv/tb_standard_event_status_block.sv
// Purpose: self-checking bench of the event status block
// Assumes: controller model drives all requests except those of the generic register
// Notes:   generic register driven by the bench
`timescale 1ns/1ns
module tb_standard_event_status_block;
  reg         clock = 0, arst_n = 0, ok;
  reg  [15:0] v;
  integer     n_mismatch = 0, samples_checked = 0, i;
  wire        queue_event_valid, queue_device_err, queue_exec_err, queue_cmd_err;
  wire        op_done_cmd, ops_pending, wait_cmd, enable_write, latch_read;
  wire        latch_value_valid, event_summary, exec_hold;
  wire [15:0] enable_value, latch_value, enable_readback;
  wire [7:0]  status_byte_part;
  reg  [15:0] aux_condition = 16'h0000, aux_enable_value = 16'h0000;
  reg         aux_enable_write = 0, aux_read = 0;
  wire [15:0] aux_value;
  wire        aux_summary;
  always #2 clock = ~clock;
  controller_model i_ctl (.*);
  std_event_status i_dut (.*);
  task chk(input [15:0] e, g, input [63:0] nm); begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  end endtask
  task end_sim; begin
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  task t_reset; begin
    chk(16'h0000, enable_readback, "mask");
    i_ctl.query(v, ok);
    chk(16'h0001, {15'h0, ok}, "valid");
    chk(16'h0000, v, "empty");
  end endtask
  task t_events; begin
    for (i = 3; i < 6; i = i + 1) begin
      i_ctl.mask(16'h0001 << i);
      i_ctl.send(i == 3, i == 4, i == 5);
      if (i == 4) repeat (3) @(negedge clock);
      chk(16'h0020, {8'h00, status_byte_part}, "stb");
      i_ctl.query(v, ok);
      chk(16'h0001 << i, v, "latch");
      chk(16'h0000, {15'h0, event_summary}, "clear");
    end
  end endtask
  task t_opc; begin
    i_ctl.ops_pending = 1;
    i_ctl.cmd(0);
    repeat (3) @(negedge clock);
    i_ctl.query(v, ok);
    chk(16'h0000, v, "opc_wait");
    i_ctl.ops_pending = 0;
    repeat (3) @(negedge clock);
    i_ctl.query(v, ok);
    chk(16'h0001, v, "opc_done");
  end endtask
  task t_wait; begin
    i_ctl.ops_pending = 1;
    i_ctl.cmd(1);
    chk(16'h0001, {15'h0, exec_hold}, "hold");
    @(negedge clock);
    chk(16'h0001, {15'h0, exec_hold}, "hold2");
    i_ctl.ops_pending = 0;
    #1 chk(16'h0000, {15'h0, exec_hold}, "go");
    @(negedge clock) i_ctl.ops_pending = 1;
    #1 chk(16'h0000, {15'h0, exec_hold}, "no_wait");
    i_ctl.ops_pending = 0;
  end endtask
  task t_aux; begin
    @(negedge clock) aux_enable_value = 16'h0200;
    aux_enable_write = 1;
    @(negedge clock) aux_enable_write = 0;
    aux_condition = 16'h0201;
    @(negedge clock) aux_condition = 16'h0000;
    chk(16'h0001, {15'h0, aux_summary}, "aux_sum");
    aux_read = 1;
    @(negedge clock) aux_read = 0;
    chk(16'h0201, aux_value, "aux_val");
    chk(16'h0000, {15'h0, aux_summary}, "aux_clr");
  end endtask
  task t_rst2; begin
    i_ctl.mask(16'h0010);
    i_ctl.send(1, 0, 0);
    chk(16'h0000, {15'h0, event_summary}, "gate");
    i_ctl.query(v, ok);
    chk(16'h0008, v, "dev");
    i_ctl.mask(16'h0039);
    chk(16'h0039, enable_readback, "mask_w");
    @(negedge clock) arst_n = 0;
    @(negedge clock) arst_n = 1;
    chk(16'h0000, enable_readback, "mask_rst");
  end endtask
  initial begin
    repeat (8) @(negedge clock);
    arst_n = 1;
    t_reset;
    t_events;
    t_opc;
    t_wait;
    t_aux;
    t_rst2;
    end_sim;
  end
  initial begin
    #100000 n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule
